// *** include/lockdet_pkg.sv ***
package lockdet_pkg;

    // ==========================================================
    // Widths.
    localparam int SAMPLE_W  = 24;
    localparam int OFFSET_W  = 14;
    localparam int THRESH_W  = 32;
    localparam int XEXP_W    = 5;
    localparam int YEXP_W    = 3;
    localparam int PEXP_W    = 4;
    localparam int DIV_W     = 16;
    localparam int CNT_W     = 21;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int IRQ_W     = 4;

    // ==========================================================
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET      = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_THR   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_THR    = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_WDOG  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_WDOG   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h20;

    // ==========================================================
    // Field positions.
    localparam int WDOG_X_LSB  = 0;
    localparam int WDOG_Y_LSB  = 8;
    localparam int IRQ_PLOCK   = 0;
    localparam int IRQ_PUNLOCK = 1;
    localparam int IRQ_FLOCK   = 2;
    localparam int IRQ_FUNLOCK = 3;

    // ==========================================================
    // Reset values and constants.
    localparam logic [PEXP_W-1:0]   RST_PEXP   = 4'h0;
    localparam logic [OFFSET_W-1:0] RST_OFFSET = 14'h0000;
    localparam logic [THRESH_W-1:0] RST_THRESH = 32'h0000_0000;
    localparam logic [XEXP_W-1:0]   RST_X      = 5'h00;
    localparam logic [YEXP_W-1:0]   RST_Y      = 3'h0;
    localparam logic [IRQ_W-1:0]    RST_IRQ    = 4'h0;
    localparam logic [CNT_W-1:0]    CNT_ONE    = 21'h000001;
    localparam logic [DIV_W-1:0]    DIV_ONE    = 16'h0001;
    localparam logic [3:0]          Y_STEP     = 4'h1;

    // ==========================================================
    // Types.
    typedef struct packed {
        logic [YEXP_W-1:0] y;
        logic [XEXP_W-1:0] x;
    } wdog_cfg_t;

    typedef enum logic {
        ST_SEARCH = 1'b0,
        ST_LOCKED = 1'b1
    } lock_state_t;

endpackage : lockdet_pkg

// *** design/decim_divider.sv ***
`timescale 1ns/100ps
module decim_divider (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_srst,
    input  wire logic [lockdet_pkg::PEXP_W-1:0] i_pexp,
    output logic                               o_tick
);

    logic [lockdet_pkg::DIV_W-1:0] cnt_q;
    logic [lockdet_pkg::DIV_W-1:0] mask;

    // ==========================================================
    // Power-of-two divider.
    assign mask = (lockdet_pkg::DIV_ONE << i_pexp) - lockdet_pkg::DIV_ONE;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_q  <= cnt_q + lockdet_pkg::DIV_ONE;
            o_tick <= ((cnt_q & mask) == mask);
        end
    end

    a_div_by_two : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (o_tick && i_pexp != '0 && $stable(i_pexp)) |=> !o_tick)
        else $error("Divider ticked twice in a row while dividing.");

endmodule : decim_divider

// *** design/lock_watchdog.sv ***
`timescale 1ns/100ps
module lock_watchdog (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_srst,
    input  wire logic                   i_tick,
    input  wire logic                   i_comp,
    input  wire lockdet_pkg::wdog_cfg_t i_cfg,
    output logic                        o_locked,
    output logic                        o_lock_evt,
    output logic                        o_unlock_evt
);

    lockdet_pkg::lock_state_t       state_q;
    logic                           comp_prev_q;
    logic [lockdet_pkg::CNT_W-1:0]  cnt_q;
    logic [lockdet_pkg::CNT_W-1:0]  target;
    logic [3:0]                     y_plus;
    logic                           qual;
    logic                           changed;
    logic                           hit;

    // ==========================================================
    // Run counter.
    assign y_plus  = {1'b0, i_cfg.y} + lockdet_pkg::Y_STEP;
    assign qual    = (state_q == lockdet_pkg::ST_SEARCH) ? i_comp : !i_comp;
    assign target  = (state_q == lockdet_pkg::ST_SEARCH) ?
                     (lockdet_pkg::CNT_ONE << i_cfg.x) :
                     (lockdet_pkg::CNT_ONE << y_plus);
    assign changed = (i_comp != comp_prev_q);
    assign hit     = i_tick && qual && !changed && ((cnt_q + lockdet_pkg::CNT_ONE) == target);

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            comp_prev_q <= 1'b0;
        end else begin
            comp_prev_q <= i_comp;
        end
    end

    // A change of the comparator restarts the run, so only unbroken runs count.
    always_ff @(posedge i_core_clk) begin
        if (i_srst || changed || hit) begin
            cnt_q <= '0;
        end else if (i_tick && qual) begin
            cnt_q <= cnt_q + lockdet_pkg::CNT_ONE;
        end
    end

    // ==========================================================
    // Lock state.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_q      <= lockdet_pkg::ST_SEARCH;
            o_locked     <= 1'b0;
            o_lock_evt   <= 1'b0;
            o_unlock_evt <= 1'b0;
        end else begin
            o_lock_evt   <= hit && (state_q == lockdet_pkg::ST_SEARCH);
            o_unlock_evt <= hit && (state_q == lockdet_pkg::ST_LOCKED);
            if (hit) begin
                unique case (state_q)
                    lockdet_pkg::ST_SEARCH: begin
                        state_q  <= lockdet_pkg::ST_LOCKED;
                        o_locked <= 1'b1;
                    end
                    lockdet_pkg::ST_LOCKED: begin
                        state_q  <= lockdet_pkg::ST_SEARCH;
                        o_locked <= 1'b0;
                    end
                endcase
            end
        end
    end

    a_lock_on_true : assert property (@(posedge i_core_clk) disable iff (i_srst)
        $rose(o_locked) |-> $past(i_comp) && $past(i_tick) && o_lock_evt)
        else $error("Lock rose without a true comparator and a tick.");
    a_lock_holds : assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(o_locked) |-> o_unlock_evt && !$past(i_comp, 2))
        else $error("Lock fell without an unlock event.");
    // Even the shortest unlock window needs a comparator change and two further ticks.
    a_unlock_wait : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (o_unlock_evt && $stable(i_cfg)) |-> !$past(o_lock_evt) && !$past(o_lock_evt, 2))
        else $error("Unlock declared after fewer than two periods.");

endmodule : lock_watchdog

// *** design/pll_phase_offset_lock_detect.sv ***
`timescale 1ns/100ps
module pll_phase_offset_lock_detect (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_srst,
    input  wire logic [lockdet_pkg::SAMPLE_W-1:0]  i_pd_sample,
    input  wire logic                              i_pd_valid,
    input  wire logic [lockdet_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [lockdet_pkg::DATA_W-1:0]    i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [lockdet_pkg::DATA_W-1:0]    o_rdata_q,
    output logic      [lockdet_pkg::SAMPLE_W-1:0]  o_pd_adj_q,
    output logic                                   o_pd_adj_valid_q,
    output logic                                   o_phase_lock,
    output logic                                   o_freq_lock,
    output logic                                   o_irq_q
);

    localparam int MAG_W = lockdet_pkg::SAMPLE_W + 1;

    logic [lockdet_pkg::PEXP_W-1:0]   pexp_q;
    logic [lockdet_pkg::OFFSET_W-1:0] offset_q;
    logic [lockdet_pkg::THRESH_W-1:0] phase_thr_q;
    logic [lockdet_pkg::THRESH_W-1:0] freq_thr_q;
    lockdet_pkg::wdog_cfg_t           phase_cfg_q;
    lockdet_pkg::wdog_cfg_t           freq_cfg_q;
    logic [lockdet_pkg::IRQ_W-1:0]    irq_stat_q;
    logic [lockdet_pkg::IRQ_W-1:0]    irq_mask_q;
    logic [lockdet_pkg::IRQ_W-1:0]    irq_evt;
    logic [lockdet_pkg::SAMPLE_W-1:0] adj;
    logic [lockdet_pkg::SAMPLE_W-1:0] prev_q;
    logic                             prev_valid_q;
    logic [MAG_W-1:0]                 diff;
    logic                             phase_comp_q;
    logic                             freq_comp_q;
    logic                             tick;
    logic                             p_lock_evt;
    logic                             p_unlock_evt;
    logic                             f_lock_evt;
    logic                             f_unlock_evt;
    logic                             rd_irq;
    logic [lockdet_pkg::DATA_W-1:0]   rd_mux;

    // ==========================================================
    // Helpers.
    function automatic logic [lockdet_pkg::THRESH_W-1:0] mag32(input logic [MAG_W-1:0] v);
        logic [MAG_W-1:0] a;
        a = v[MAG_W-1] ? (~v + {{(MAG_W-1){1'b0}}, 1'b1}) : v;
        return {{(lockdet_pkg::THRESH_W-MAG_W){1'b0}}, a};
    endfunction : mag32

    function automatic logic hit_addr(input logic [lockdet_pkg::ADDR_W-1:0] a,
                                      input logic [lockdet_pkg::ADDR_W-1:0] b);
        return (a == b);
    endfunction : hit_addr

    // ==========================================================
    // Register writes.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pexp_q      <= lockdet_pkg::RST_PEXP;
            offset_q    <= lockdet_pkg::RST_OFFSET;
            phase_thr_q <= lockdet_pkg::RST_THRESH;
            freq_thr_q  <= lockdet_pkg::RST_THRESH;
            phase_cfg_q <= '{y: lockdet_pkg::RST_Y, x: lockdet_pkg::RST_X};
            freq_cfg_q  <= '{y: lockdet_pkg::RST_Y, x: lockdet_pkg::RST_X};
            irq_mask_q  <= lockdet_pkg::RST_IRQ;
        end else if (i_wr) begin
            if (hit_addr(i_addr, lockdet_pkg::ADDR_CTRL)) begin
                pexp_q <= i_wdata[lockdet_pkg::PEXP_W-1:0];
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_OFFSET)) begin
                offset_q <= i_wdata[lockdet_pkg::OFFSET_W-1:0];
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_PHASE_THR)) begin
                phase_thr_q <= i_wdata;
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_FREQ_THR)) begin
                freq_thr_q <= i_wdata;
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_PHASE_WDOG)) begin
                phase_cfg_q.x <= i_wdata[lockdet_pkg::WDOG_X_LSB +: lockdet_pkg::XEXP_W];
                phase_cfg_q.y <= i_wdata[lockdet_pkg::WDOG_Y_LSB +: lockdet_pkg::YEXP_W];
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_FREQ_WDOG)) begin
                freq_cfg_q.x <= i_wdata[lockdet_pkg::WDOG_X_LSB +: lockdet_pkg::XEXP_W];
                freq_cfg_q.y <= i_wdata[lockdet_pkg::WDOG_Y_LSB +: lockdet_pkg::YEXP_W];
            end
            if (hit_addr(i_addr, lockdet_pkg::ADDR_IRQ_MASK)) begin
                irq_mask_q <= i_wdata[lockdet_pkg::IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // Offset adder.
    // The sum wraps; software keeps the offset in 12 signed bits so it never nears the edge.
    assign adj = i_pd_sample + {{(lockdet_pkg::SAMPLE_W-lockdet_pkg::OFFSET_W)
                 {offset_q[lockdet_pkg::OFFSET_W-1]}}, offset_q};

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_pd_adj_q       <= '0;
            o_pd_adj_valid_q <= 1'b0;
        end else begin
            o_pd_adj_valid_q <= i_pd_valid;
            if (i_pd_valid) begin
                o_pd_adj_q <= adj;
            end
        end
    end

    // ==========================================================
    // Comparators.
    assign diff = {adj[lockdet_pkg::SAMPLE_W-1], adj} -
                  {prev_q[lockdet_pkg::SAMPLE_W-1], prev_q};

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            prev_q       <= '0;
            prev_valid_q <= 1'b0;
        end else if (i_pd_valid) begin
            prev_q       <= adj;
            prev_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            phase_comp_q <= 1'b0;
        end else if (i_pd_valid) begin
            phase_comp_q <= (mag32({adj[lockdet_pkg::SAMPLE_W-1], adj}) <= phase_thr_q);
        end
    end

    // The first sample has no predecessor, so frequency qualification starts one sample later.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            freq_comp_q <= 1'b0;
        end else if (i_pd_valid) begin
            freq_comp_q <= prev_valid_q && (mag32(diff) <= freq_thr_q);
        end
    end

    // ==========================================================
    // Decimated clock and watchdogs.
    decim_divider u_div (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_pexp     (pexp_q),
        .o_tick     (tick)
    );

    lock_watchdog u_phase_wd (
        .i_core_clk   (i_core_clk),
        .i_srst       (i_srst),
        .i_tick       (tick),
        .i_comp       (phase_comp_q),
        .i_cfg        (phase_cfg_q),
        .o_locked     (o_phase_lock),
        .o_lock_evt   (p_lock_evt),
        .o_unlock_evt (p_unlock_evt)
    );

    lock_watchdog u_freq_wd (
        .i_core_clk   (i_core_clk),
        .i_srst       (i_srst),
        .i_tick       (tick),
        .i_comp       (freq_comp_q),
        .i_cfg        (freq_cfg_q),
        .o_locked     (o_freq_lock),
        .o_lock_evt   (f_lock_evt),
        .o_unlock_evt (f_unlock_evt)
    );

    // ==========================================================
    // Interrupts.
    always_comb begin
        irq_evt                           = '0;
        irq_evt[lockdet_pkg::IRQ_PLOCK]   = p_lock_evt;
        irq_evt[lockdet_pkg::IRQ_PUNLOCK] = p_unlock_evt;
        irq_evt[lockdet_pkg::IRQ_FLOCK]   = f_lock_evt;
        irq_evt[lockdet_pkg::IRQ_FUNLOCK] = f_unlock_evt;
    end

    assign rd_irq = i_rd && hit_addr(i_addr, lockdet_pkg::ADDR_IRQ_STATUS);

    // A read clears the status, but an event in the same cycle survives it.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            irq_stat_q <= lockdet_pkg::RST_IRQ;
        end else begin
            irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | irq_evt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_irq_q <= 1'b0;
        end else begin
            o_irq_q <= |(((rd_irq ? '0 : irq_stat_q) | irq_evt) & irq_mask_q);
        end
    end

    // ==========================================================
    // Register reads.
    always_comb begin
        rd_mux = '0;
        unique case (i_addr)
            lockdet_pkg::ADDR_CTRL:        rd_mux[lockdet_pkg::PEXP_W-1:0] = pexp_q;
            lockdet_pkg::ADDR_OFFSET:      rd_mux[lockdet_pkg::OFFSET_W-1:0] = offset_q;
            lockdet_pkg::ADDR_PHASE_THR:   rd_mux = phase_thr_q;
            lockdet_pkg::ADDR_FREQ_THR:    rd_mux = freq_thr_q;
            lockdet_pkg::ADDR_PHASE_WDOG: begin
                rd_mux[lockdet_pkg::WDOG_X_LSB +: lockdet_pkg::XEXP_W] = phase_cfg_q.x;
                rd_mux[lockdet_pkg::WDOG_Y_LSB +: lockdet_pkg::YEXP_W] = phase_cfg_q.y;
            end
            lockdet_pkg::ADDR_FREQ_WDOG: begin
                rd_mux[lockdet_pkg::WDOG_X_LSB +: lockdet_pkg::XEXP_W] = freq_cfg_q.x;
                rd_mux[lockdet_pkg::WDOG_Y_LSB +: lockdet_pkg::YEXP_W] = freq_cfg_q.y;
            end
            lockdet_pkg::ADDR_LOCK_STATUS: rd_mux[1:0] = {o_freq_lock, o_phase_lock};
            lockdet_pkg::ADDR_IRQ_STATUS:  rd_mux[lockdet_pkg::IRQ_W-1:0] = irq_stat_q;
            lockdet_pkg::ADDR_IRQ_MASK:    rd_mux[lockdet_pkg::IRQ_W-1:0] = irq_mask_q;
            default:                       rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rdata_q <= '0;
        end else begin
            o_rdata_q <= i_rd ? rd_mux : '0;
        end
    end

    // ==========================================================
    // Checks.
    a_offset_added : assert property (@(posedge i_core_clk) disable iff (i_srst)
        i_pd_valid |=> o_pd_adj_q == $past(i_pd_sample) +
        {{(lockdet_pkg::SAMPLE_W-lockdet_pkg::OFFSET_W)
        {$past(offset_q[lockdet_pkg::OFFSET_W-1])}}, $past(offset_q)})
        else $error("Adjusted sample does not carry the signed offset.");
    a_phase_compare : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_pd_valid && mag32({adj[lockdet_pkg::SAMPLE_W-1], adj}) > phase_thr_q)
        |=> !phase_comp_q)
        else $error("Phase comparator true above threshold.");
    a_phase_within : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_pd_valid && mag32({adj[lockdet_pkg::SAMPLE_W-1], adj}) <= phase_thr_q)
        |=> phase_comp_q)
        else $error("Phase comparator false within threshold.");
    a_freq_compare : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_pd_valid && prev_valid_q && mag32(diff) > freq_thr_q) |=> !freq_comp_q)
        else $error("Frequency comparator true above threshold.");
    a_irq_level : assert property (@(posedge i_core_clk) disable iff (i_srst)
        (p_lock_evt && irq_mask_q[lockdet_pkg::IRQ_PLOCK] && $stable(irq_mask_q))
        |=> o_irq_q && irq_stat_q[lockdet_pkg::IRQ_PLOCK])
        else $error("Lock event did not raise the interrupt.");

endmodule : pll_phase_offset_lock_detect

// *** dv/pll_phase_offset_lock_detect_test.sv ***
`timescale 1ns/100ps
module pll_phase_offset_lock_detect_test;
    // ==========================================================
    // Bench state.
    logic        i_core_clk;
    logic        i_srst;
    logic [23:0] i_pd_sample;
    logic        i_pd_valid;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata_q;
    logic [23:0] o_pd_adj_q;
    logic        o_pd_adj_valid_q;
    logic        o_phase_lock;
    logic        o_freq_lock;
    logic        o_irq_q;
    int          fail_count;
    int          check_count;
    int          cyc;
    pll_phase_offset_lock_detect dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_pd_sample(i_pd_sample), .i_pd_valid(i_pd_valid), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_q(o_rdata_q),
        .o_pd_adj_q(o_pd_adj_q), .o_pd_adj_valid_q(o_pd_adj_valid_q),
        .o_phase_lock(o_phase_lock), .o_freq_lock(o_freq_lock), .o_irq_q(o_irq_q));
    // ==========================================================
    // Shared tasks.
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk_rng(input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("MISMATCH at %0t: waited %0d cycles, allowed %0d..%0d", $time, n, lo, hi);
        end
    endtask : chk_rng
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata_q;
    endtask : rd
    task smp(input logic [23:0] v);
        @(posedge i_core_clk);
        i_pd_sample <= v;
        i_pd_valid  <= 1'b1;
    endtask : smp
    // Bounded wait, so a flag that never moves cannot hang the run.
    task wait_for(input bit sel, input logic val, input int lim, output int n);
        n = 0;
        while (n < lim) begin
            @(posedge i_core_clk);
            #1 n++;
            if ((sel ? o_freq_lock : o_phase_lock) === val) break;
        end
    endtask : wait_for
    // ==========================================================
    // Scenarios.
    task test_regs;
        logic [31:0] d;
        rd(lockdet_pkg::ADDR_OFFSET, d);
        chk(d, 32'h0000_0000);
        @(posedge i_core_clk);
        #1 chk(o_rdata_q, 32'h0000_0000);
        chk(o_pd_adj_valid_q, 1'b0);
        wr(lockdet_pkg::ADDR_PHASE_THR, 32'h8000_0001);
        rd(lockdet_pkg::ADDR_PHASE_THR, d);
        chk(d, 32'h8000_0001);
        wr(8'h40, 32'h1234_5678);
        rd(8'h40, d);
        chk(d, 32'h0000_0000);
        rd(lockdet_pkg::ADDR_IRQ_STATUS, d);
        chk(d, 32'h0000_0000);
    endtask : test_regs
    task test_offset;
        logic [31:0] d;
        wr(lockdet_pkg::ADDR_OFFSET, 32'h0000_3800);
        rd(lockdet_pkg::ADDR_OFFSET, d);
        chk(d, 32'h0000_3800);
        smp(24'h000064);
        @(posedge i_core_clk);
        #1 chk({8'h00, o_pd_adj_q}, 32'h00ff_f864);
        chk(o_pd_adj_valid_q, 1'b1);
        wr(lockdet_pkg::ADDR_OFFSET, 32'h0000_07ff);
        @(posedge i_core_clk);
        #1 chk({8'h00, o_pd_adj_q}, 32'h0000_0863);
        wr(lockdet_pkg::ADDR_OFFSET, 32'h0000_0000);
    endtask : test_offset
    task test_lock;
        logic [31:0] d;
        int          n;
        logic [23:0] v;
        // Earlier scenarios leave both detectors locked, so start again from reset.
        @(posedge i_core_clk);
        i_srst     <= 1'b1;
        i_pd_valid <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        #1 chk(o_phase_lock, 1'b0);
        chk(o_freq_lock, 1'b0);
        wr(lockdet_pkg::ADDR_PHASE_THR, 32'h0000_000a);
        wr(lockdet_pkg::ADDR_FREQ_THR, 32'h0000_0005);
        wr(lockdet_pkg::ADDR_PHASE_WDOG, 32'h0000_0002);
        wr(lockdet_pkg::ADDR_FREQ_WDOG, 32'h0000_0003);
        wr(lockdet_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        // A sample equal to the threshold still counts as aligned.
        smp(24'h00000a);
        wait_for(1'b0, 1'b1, 40, n);
        chk_rng(n, 4, 8);
        wait_for(1'b1, 1'b1, 20, n);
        chk_rng(n, 3, 8);
        @(posedge i_core_clk);
        #1 chk(o_irq_q, 1'b1);
        rd(lockdet_pkg::ADDR_IRQ_STATUS, d);
        chk(d, 32'h0000_0005);
        @(posedge i_core_clk);
        #1 chk(o_irq_q, 1'b0);
        // Magnitude 11 above a threshold of 10: only the absolute value can fail it.
        smp(24'hfffff5);
        wait_for(1'b0, 1'b0, 40, n);
        chk_rng(n, 2, 6);
        chk(o_freq_lock, 1'b1);
        chk(o_irq_q, 1'b0);
        v = 24'hfffff5;
        repeat (8) begin
            v = v - 24'h000014;
            smp(v);
        end
        #1 chk(o_freq_lock, 1'b0);
    endtask : test_lock
    task test_runs;
        int n;
        repeat (6) begin
            repeat (3) smp(24'h000003);
            smp(24'h000032);
            #1 chk(o_phase_lock, 1'b0);
        end
        wr(lockdet_pkg::ADDR_CTRL, 32'h0000_0002);
        smp(24'h000003);
        wait_for(1'b0, 1'b1, 100, n);
        chk_rng(n, 14, 26);
    endtask : test_runs
    // ==========================================================
    // Clock, timeout and main sequence.
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        {i_srst, i_pd_sample, i_pd_valid, i_addr, i_wdata, i_wr, i_rd} = '0;
        i_srst      = 1'b1;
        fail_count  = 0;
        check_count = 0;
        cyc         = 0;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        test_regs();
        test_offset();
        test_lock();
        test_runs();
        stop_test();
    end
endmodule : pll_phase_offset_lock_detect_test
